// [design/dodt_pkg.sv]
// How it works
// - Dynamic termination is on when either write-termination select bit is one.
// - Nominal code 000 off, 001 /4, 010 /2, 011 /6, 100 /12, 101 /8; others reserved.
// - Write code 01 selects /4, 10 selects /2, 11 reserved.
// - Write code 00 leaves nominal termination untouched during writes.
// - Idle: nominal strength, switched by ODT pin after turn-on/turn-off latency.
// - Any write switches to write termination write latency minus two later.
// - Back to nominal after 6 plus off latency (BL8) or 4 plus it (BC4).
// - Value undefined during change-skew window after the switch.
// - On/off timing follows ODT pin; controller honours minimum high times.
// - General nominal timing stays in force under dynamic mode.
// - Device tolerates ODT stuck high in the tied-high configuration.
// - After such a load termination settles within bounded latency, may toggle before.
// - Write leveling: strobes get nominal, data none; after exit both follow normal termination again.
// - Turn-on and turn-off latency both equal CWL plus AL minus two.
package dodt_pkg;
   // Register byte offsets
   localparam logic [3:0] REG_MR1 = 4'h0;
   localparam logic [3:0] REG_MR2 = 4'h4;
   localparam logic [3:0] REG_LAT = 4'h8;
   localparam logic [3:0] REG_STAT = 4'hc;
   // MR1/MR2 field positions
   localparam int MR1_NOM_B2 = 2;
   localparam int MR1_NOM_B6 = 6;
   localparam int MR1_NOM_B9 = 9;
   localparam int MR1_WLEV_B = 7;
   localparam int MR1_AL_LO = 3;
   localparam int MR2_CWL_LO = 3;
   localparam int MR2_WR_LO = 9;
   // Reset values
   localparam logic [15:0] MR1_RST = 16'h0000;
   localparam logic [15:0] MR2_RST = 16'h0000;
   localparam logic [7:0] LAT_RST = 8'h05;
   // Timing counts in clocks
   localparam logic [5:0] ODT_LAT_SUB = 6'h02;
   localparam logic [5:0] CWN4_ADD = 6'h04;
   localparam logic [5:0] CWN8_ADD = 6'h06;
   localparam logic [5:0] TMOD_CK = 6'h0c;
   localparam logic [5:0] SETTLE_ADD = 6'h02;
   localparam int CWL_BASE = 5;
   // Nominal codes
   localparam logic [2:0] NOM_OFF = 3'h0;
   localparam logic [2:0] NOM_RZQ4 = 3'h1;
   localparam logic [2:0] NOM_RZQ2 = 3'h2;
   localparam logic [2:0] NOM_RZQ6 = 3'h3;
   localparam logic [2:0] NOM_RZQ12 = 3'h4;
   localparam logic [2:0] NOM_RZQ8 = 3'h5;
   // Write codes
   localparam logic [1:0] WR_OFF = 2'h0;
   localparam logic [1:0] WR_RZQ4 = 2'h1;
   localparam logic [1:0] WR_RZQ2 = 2'h2;
   // Termination output encoding: RZQ divisor, 0 = off
   localparam logic [3:0] TERM_OFF = 4'h0;
   typedef enum logic [2:0] {
      DODT_NOM = 3'b001,
      DODT_WR = 3'b010,
      DODT_SKEW = 3'b100
   } dodt_mode_e;
endpackage

// [design/dodt_delay.sv]
`timescale 1ns/1ps
// Programmable delay line for the pin level: output is input delayed by lat_i clocks
module dodt_delay (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Data
   input wire logic d_i,
   input wire logic [5:0] lat_i,
   output logic q_o
);
   typedef struct packed {
      logic [63:0] sh;
   } dodt_dly_s;
   dodt_dly_s st, next_st;
   always_comb begin
      next_st = st;
      next_st.sh = {st.sh[62:0], d_i};
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   // Latency zero passes the sampled pin straight through
   assign q_o = (lat_i == 6'h00) ? d_i : st.sh[lat_i - 6'h01];
endmodule

// [design/dodt_decode.sv]
`timescale 1ns/1ps
// Maps mode register codes to RZQ divisors
module dodt_decode (
   // Codes
   input wire logic [2:0] nom_code_i,
   input wire logic [1:0] wr_code_i,
   // Divisors
   output logic [3:0] nom_div_o,
   output logic [3:0] wr_div_o,
   output logic nom_bad_o,
   output logic wr_bad_o
);
   always_comb begin
      nom_bad_o = 1'b0;
      unique case (nom_code_i)
         dodt_pkg::NOM_OFF: nom_div_o = dodt_pkg::TERM_OFF;
         dodt_pkg::NOM_RZQ4: nom_div_o = 4'h4;
         dodt_pkg::NOM_RZQ2: nom_div_o = 4'h2;
         dodt_pkg::NOM_RZQ6: nom_div_o = 4'h6;
         dodt_pkg::NOM_RZQ12: nom_div_o = 4'hc;
         dodt_pkg::NOM_RZQ8: nom_div_o = 4'h8;
         default: begin
            // Reserved: terminate nothing rather than guess
            nom_div_o = dodt_pkg::TERM_OFF;
            nom_bad_o = 1'b1;
         end
      endcase
      wr_bad_o = 1'b0;
      unique case (wr_code_i)
         dodt_pkg::WR_OFF: wr_div_o = dodt_pkg::TERM_OFF;
         dodt_pkg::WR_RZQ4: wr_div_o = 4'h4;
         dodt_pkg::WR_RZQ2: wr_div_o = 4'h2;
         default: begin
            wr_div_o = dodt_pkg::TERM_OFF;
            wr_bad_o = 1'b1;
         end
      endcase
   end
endmodule

// [design/dodt_ctrl.sv]
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
// Dynamic on-die termination controller
module dodt_ctrl (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // DRAM side
   input wire logic odt_i,
   input wire logic wr_cmd_i,
   input wire logic wr_bc4_i,
   input wire logic mr1_load_i,
   input wire logic [15:0] mr1_val_i,
   // Termination
   output logic [3:0] dq_term_o,
   output logic [3:0] dqs_term_o,
   output logic term_undef_o,
   output logic wr_term_o
);
   typedef struct packed {
      logic odt_m;
      logic odt_s;
      logic [15:0] mr1;
      logic [15:0] mr2;
      logic [7:0] lat;
      dodt_pkg::dodt_mode_e mode;
      logic [5:0] cnw_cnt;
      logic cnw_run;
      logic [5:0] cwn_cnt;
      logic cwn_run;
      logic [5:0] settle_cnt;
      logic wr_seen;
      logic ack;
      logic [31:0] rdat;
      logic [3:0] dq_term;
      logic [3:0] dqs_term;
      logic undef;
   } dodt_st_s;

   dodt_st_s st, next_st;
   logic [2:0] nom_code;
   logic [3:0] nom_div, wr_div;
   logic nom_bad, wr_bad;
   logic dyn_en, wlev, pin_on;
   logic [5:0] wl, odtl, cwn_len;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
      merge16 = old;
      if (sel[0]) begin
         merge16[7:0] = d[7:0];
      end
      if (sel[1]) begin
         merge16[15:8] = d[15:8];
      end
   endfunction

   assign nom_code = {st.mr1[dodt_pkg::MR1_NOM_B9], st.mr1[dodt_pkg::MR1_NOM_B6],
                      st.mr1[dodt_pkg::MR1_NOM_B2]};
   assign dyn_en = st.mr2[dodt_pkg::MR2_WR_LO] | st.mr2[dodt_pkg::MR2_WR_LO + 1];
   assign wlev = st.mr1[dodt_pkg::MR1_WLEV_B];
   // Write latency: CWL from MR2[5:3] plus AL from MR1[4:3] (0, CL-1, CL-2 as held in lat)
   always_comb begin
      logic [5:0] al;
      al = 6'h00;
      unique case (st.mr1[dodt_pkg::MR1_AL_LO +: 2])
         2'h1: al = {2'h0, st.lat[7:4]} - 6'h01;
         2'h2: al = {2'h0, st.lat[7:4]} - 6'h02;
         default: al = 6'h00;
      endcase
      wl = 6'(dodt_pkg::CWL_BASE) + {3'h0, st.mr2[dodt_pkg::MR2_CWL_LO +: 3]} + al;
   end
   assign odtl = wl - dodt_pkg::ODT_LAT_SUB;
   assign cwn_len = (wr_bc4_i ? dodt_pkg::CWN4_ADD : dodt_pkg::CWN8_ADD) + odtl;

   dodt_decode u_dec (
      .nom_code_i(nom_code),
      .wr_code_i(st.mr2[dodt_pkg::MR2_WR_LO +: 2]),
      .nom_div_o(nom_div),
      .wr_div_o(wr_div),
      .nom_bad_o(nom_bad),
      .wr_bad_o(wr_bad)
   );

   // Same latency for on and off, so one delay line serves both edges
   dodt_delay u_dly (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(st.odt_s),
      .lat_i(odtl),
      .q_o(pin_on)
   );

   always_comb begin
      logic hit;
      logic [3:0] strength;
      hit = wb_cyc_i & wb_stb_i & ~st.ack;
      strength = dodt_pkg::TERM_OFF;
      next_st = st;
      next_st.odt_m = odt_i;
      next_st.odt_s = st.odt_m;
      next_st.ack = hit;
      // Bus
      if (hit && wb_we_i) begin
         unique case (wb_adr_i)
            dodt_pkg::REG_MR1: begin
               next_st.mr1 = merge16(st.mr1, wb_dat_i, wb_sel_i);
               next_st.settle_cnt = odtl + dodt_pkg::TMOD_CK + dodt_pkg::SETTLE_ADD;
            end
            dodt_pkg::REG_MR2: next_st.mr2 = merge16(st.mr2, wb_dat_i, wb_sel_i);
            dodt_pkg::REG_LAT: begin
               if (wb_sel_i[0]) begin
                  next_st.lat = wb_dat_i[7:0];
               end
            end
            default: ;
         endcase
      end
      if (hit && !wb_we_i) begin
         unique case (wb_adr_i)
            dodt_pkg::REG_MR1: next_st.rdat = {16'h0000, st.mr1};
            dodt_pkg::REG_MR2: next_st.rdat = {16'h0000, st.mr2};
            dodt_pkg::REG_LAT: next_st.rdat = {24'h000000, st.lat};
            dodt_pkg::REG_STAT: next_st.rdat = {16'h0000, wr_bad, nom_bad, st.undef, st.mode,
                                                  st.dq_term, st.dqs_term, wlev, dyn_en};
            default: next_st.rdat = 32'h00000000;
         endcase
      end
      // Command-path MR1 load also restarts settling
      if (mr1_load_i) begin
         next_st.mr1 = mr1_val_i;
         next_st.settle_cnt = odtl + dodt_pkg::TMOD_CK + dodt_pkg::SETTLE_ADD;
      end else if (st.settle_cnt != 6'h00) begin
         next_st.settle_cnt = st.settle_cnt - 6'h01;
      end
      // Write tracking; a later write restarts both latencies
      if (st.cnw_run) begin
         next_st.cnw_cnt = st.cnw_cnt - 6'h01;
      end
      if (st.cwn_run) begin
         next_st.cwn_cnt = st.cwn_cnt - 6'h01;
      end
      next_st.undef = 1'b0;
      unique case (st.mode)
         dodt_pkg::DODT_NOM: begin
            if (st.cnw_run && st.cnw_cnt <= 6'h01) begin
               next_st.cnw_run = 1'b0;
               next_st.mode = dodt_pkg::DODT_SKEW;
               next_st.undef = 1'b1;
            end
         end
         dodt_pkg::DODT_SKEW: next_st.mode = dodt_pkg::DODT_WR;
         dodt_pkg::DODT_WR: begin
            if (st.cwn_run && st.cwn_cnt <= 6'h01) begin
               next_st.cwn_run = 1'b0;
               next_st.mode = dodt_pkg::DODT_NOM;
            end
         end
      endcase
      if (wr_cmd_i && dyn_en) begin
         next_st.cnw_run = 1'b1;
         next_st.cnw_cnt = odtl;
         next_st.cwn_run = 1'b1;
         next_st.cwn_cnt = cwn_len;
         if (odtl == 6'h00 && st.mode == dodt_pkg::DODT_NOM) begin
            next_st.cnw_run = 1'b0;
            next_st.mode = dodt_pkg::DODT_SKEW;
            next_st.undef = 1'b1;
         end
      end
      if (!dyn_en) begin
         next_st.mode = dodt_pkg::DODT_NOM;
         next_st.cnw_run = 1'b0;
         next_st.cwn_run = 1'b0;
      end
      // Strength: write value only inside the write window
      strength = (next_st.mode == dodt_pkg::DODT_NOM) ? nom_div : wr_div;
      // ODT stuck high is harmless: with nominal off only write window terminates
      next_st.dq_term = pin_on ? strength : dodt_pkg::TERM_OFF;
      next_st.dqs_term = next_st.dq_term;
      if (wlev) begin
         // Leveling: strobes keep nominal, data pins carry none
         next_st.dq_term = dodt_pkg::TERM_OFF;
         next_st.dqs_term = pin_on ? nom_div : dodt_pkg::TERM_OFF;
      end
      if (next_st.mode == dodt_pkg::DODT_SKEW || st.settle_cnt != 6'h00) begin
         next_st.undef = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
         st.mr1 <= dodt_pkg::MR1_RST;
         st.mr2 <= dodt_pkg::MR2_RST;
         st.lat <= dodt_pkg::LAT_RST;
         st.mode <= dodt_pkg::DODT_NOM;
      end else begin
         st <= next_st;
      end
   end

   assign wb_ack_o = st.ack;
   assign wb_dat_o = st.rdat;
   assign dq_term_o = st.dq_term;
   assign dqs_term_o = st.dqs_term;
   assign term_undef_o = st.undef;
   assign wr_term_o = (st.mode != dodt_pkg::DODT_NOM);
endmodule

// [test/dodt_props.sv]
`timescale 1ns/1ps
module dodt_props (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Watched ports
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic odt_i,
   input wire logic wr_cmd_i,
   input wire logic wr_bc4_i,
   input wire logic [3:0] dq_term_o,
   input wire logic [3:0] dqs_term_o,
   input wire logic term_undef_o,
   input wire logic wr_term_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
   AST_WR_ON: assert property ($rose(wr_term_o) |-> $past(wr_cmd_i, 4))
      else $error("write termination switch at wrong cycle");
   AST_SKEW: assert property ($rose(wr_term_o) |-> term_undef_o ##1 (wr_term_o && !term_undef_o))
      else $error("skew cycle wrong");
   AST_WR_OFF: assert property ($fell(wr_term_o) |-> ($past(wr_cmd_i, 10) && !$past(wr_bc4_i, 10))
      || ($past(wr_cmd_i, 8) && $past(wr_bc4_i, 8))) else $error("return to nominal at wrong cycle");
   AST_PIN_ON: assert property ($rose(|dqs_term_o) && !term_undef_o |-> $past(odt_i, 6))
      else $error("termination on without pin");
   AST_PIN_OFF: assert property ($fell(|dqs_term_o) && !term_undef_o && !$past(wr_term_o)
      |-> !$past(odt_i, 6)) else $error("termination off while pin high");
   AST_DIV_LEGAL: assert property (!term_undef_o |-> dq_term_o inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'hc})
      else $error("illegal divisor");
   cover property ($rose(wr_term_o));
   cover property ($fell(|dqs_term_o));
   cover property (wb_ack_o);
endmodule
bind dodt_ctrl dodt_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .odt_i, .wr_cmd_i,
   .wr_bc4_i, .dq_term_o, .dqs_term_o, .term_undef_o, .wr_term_o);

// [test/dodt_mc_model.sv]
`timescale 1ns/1ps
module dodt_mc_model (
   // Clock
   input wire logic clk_i,
   // Pins to the device
   output logic odt_o,
   output logic wr_cmd_o,
   output logic wr_bc4_o,
   output logic mr1_load_o,
   output logic [15:0] mr1_val_o
);
   int cyc = 0;
   int wr_at = -100;
   int need = 0;
   initial begin
      odt_o = 1'b0;
      wr_cmd_o = 1'b0;
      wr_bc4_o = 1'b0;
      mr1_load_o = 1'b0;
      mr1_val_o = 16'h0;
   end
   always @(posedge clk_i) cyc <= cyc + 1;
   // No reads issued, so the pin is only lowered here
   task automatic pin(input logic v);
      if (!v)
         while (cyc - wr_at < need) @(posedge clk_i);
      @(posedge clk_i);
      odt_o <= v;
   endtask
   task automatic write(input logic bc4, input int gap);
      repeat (gap) @(posedge clk_i);
      @(posedge clk_i);
      wr_cmd_o <= 1'b1;
      wr_bc4_o <= bc4;
      wr_at = cyc;
      need = bc4 ? 4 : 6;
      @(posedge clk_i);
      wr_cmd_o <= 1'b0;
      wr_bc4_o <= ~bc4;
   endtask
   // Value lines are not held after the load
   task automatic mr1(input logic [15:0] v);
      @(posedge clk_i);
      mr1_load_o <= 1'b1;
      mr1_val_o <= v;
      @(posedge clk_i);
      mr1_load_o <= 1'b0;
      mr1_val_o <= ~v;
   endtask
endmodule

// [test/dodt_ctrl_tb.sv]
`timescale 1ns/1ps
module dodt_ctrl_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, odt_i, wr_cmd_i, wr_bc4_i, mr1_load_i, term_undef_o, wr_term_o;
   logic [15:0] mr1_val_i;
   logic [3:0] dq_term_o, dqs_term_o;
   int n_mismatch = 0;
   int tests_run = 0;
   integer seed = 47;
   logic [31:0] exp_q[$];
   logic [3:0] ndiv[6] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hc, 4'h8};
   logic [3:0] wdiv[3] = '{4'h0, 4'h4, 4'h2};
   dodt_ctrl u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .odt_i, .wr_cmd_i, .wr_bc4_i, .mr1_load_i, .mr1_val_i, .dq_term_o, .dqs_term_o,
      .term_undef_o, .wr_term_o);
   dodt_mc_model u_mc (.clk_i, .odt_o(odt_i), .wr_cmd_o(wr_cmd_i), .wr_bc4_o(wr_bc4_i),
      .mr1_load_o(mr1_load_i), .mr1_val_o(mr1_val_i));
   initial forever #12.5 clk_i = ~clk_i;
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hf;
      // Only the bench timeout ends a wait for the answer
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      chk("ack", 32'h1, {31'h0, wb_ack_o});
   endtask
   task automatic rd(input logic [3:0] adr, input logic [31:0] exp);
      exp_q.push_back(exp);
      wb(1'b0, adr, 32'h0);
   endtask
   task automatic term(input logic [3:0] dq, input logic [3:0] dqs, input logic wr);
      #1;
      chk("dq_term", {28'h0, dq}, {28'h0, dq_term_o});
      chk("dqs_term", {28'h0, dqs}, {28'h0, dqs_term_o});
      chk("wr_term", {31'h0, wr}, {31'h0, wr_term_o});
   endtask
   always @(posedge clk_i)
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
         chk("rdata", exp_q.pop_front(), wb_dat_o);
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      summarize();
   end
   initial begin
      logic [15:0] m1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(dodt_pkg::REG_MR1, {16'h0, dodt_pkg::MR1_RST});
      rd(dodt_pkg::REG_MR2, {16'h0, dodt_pkg::MR2_RST});
      rd(dodt_pkg::REG_LAT, {24'h0, dodt_pkg::LAT_RST});
      wb(1'b1, 4'h2, 32'hffff);
      rd(4'h2, 32'h0);
      for (int w = 0; w < 3; w++) begin
         for (int n = 0; n < 6; n++) begin
            m1 = {6'h0, n[2], 2'h0, n[1], 3'h0, n[0], 2'h0};
            wb(1'b1, dodt_pkg::REG_MR1, {16'h0, m1});
            wb(1'b1, dodt_pkg::REG_MR2, {21'h0, w[1:0], 9'h0});
            rd(dodt_pkg::REG_MR1, {16'h0, m1});
            u_mc.pin(1'b1);
            repeat (8) @(posedge clk_i);
            term(ndiv[n], ndiv[n], 1'b0);
            // Nominal-only writes are skipped for the /12 and /8 nominal codes
            if (w != 0 || n < 4) begin
               u_mc.write(1'($random(seed)), $unsigned($random(seed)) % 3);
               repeat (5) @(posedge clk_i);
               term(w ? wdiv[w] : ndiv[n], w ? wdiv[w] : ndiv[n], w != 0);
               repeat (5) @(posedge clk_i);
               term(ndiv[n], ndiv[n], 1'b0);
            end
            u_mc.pin(1'b0);
            repeat (8) @(posedge clk_i);
            term(4'h0, 4'h0, 1'b0);
         end
      end
      wb(1'b1, dodt_pkg::REG_MR1, 32'h0);
      wb(1'b1, dodt_pkg::REG_MR2, 32'h200);
      u_mc.pin(1'b1);
      repeat (8) @(posedge clk_i);
      u_mc.write(1'b0, 0);
      repeat (5) @(posedge clk_i);
      term(4'h4, 4'h4, 1'b1);
      repeat (5) @(posedge clk_i);
      term(4'h0, 4'h0, 1'b0);
      u_mc.mr1(16'h00c0);
      repeat (20) @(posedge clk_i);
      chk("undef", 32'h0, {31'h0, term_undef_o});
      term(4'h0, 4'h2, 1'b0);
      rd(dodt_pkg::REG_STAT, {16'h0, 3'b000, dodt_pkg::DODT_NOM, 4'h0, 4'h2, 1'b1, 1'b1});
      u_mc.mr1(16'h0000);
      repeat (20) @(posedge clk_i);
      chk("undef", 32'h0, {31'h0, term_undef_o});
      term(4'h0, 4'h0, 1'b0);
      rd(dodt_pkg::REG_STAT, {16'h0, 3'b000, dodt_pkg::DODT_NOM, 8'h00, 1'b0, 1'b1});
      summarize();
   end
endmodule
